// ==== rtl/tcp_defines.svh ====
// register offsets, field positions, reset values and timing counts of the timer/pwm block
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// ************************************************************
// register byte offsets on the apb
// ************************************************************
`define TCP_OFS_TIMER0_MODE 8'h00
`define TCP_OFS_TIMER1_MODE 8'h04
`define TCP_OFS_MATCH_LOW 8'h08
`define TCP_OFS_MATCH_HIGH 8'h0C
`define TCP_OFS_PERIOD_LOW 8'h10
`define TCP_OFS_DUTY_LOW 8'h14
`define TCP_OFS_HIGH_BITS 8'h18
`define TCP_OFS_PORT5_FUNC 8'h1C
`define TCP_OFS_EDGE_SELECT 8'h20
`define TCP_OFS_CAPTURE_HOLD 8'h24
`define TCP_OFS_STATUS 8'h28

// ************************************************************
// field positions
// ************************************************************
`define TCP_TM0_RUN 0
`define TCP_TM0_CLK_LO 2
`define TCP_TM0_CAPTURE 5
`define TCP_TM1_RUN 0
`define TCP_TM1_CLK_LO 2
`define TCP_TM1_PWM_EN 5
`define TCP_TM1_CHAIN 6
`define TCP_TM1_ACTIVE_LEVEL 7
`define TCP_PORT5_PWM_PIN 6
`define TCP_STAT_T0_MATCH 0
`define TCP_STAT_TRIGGER 1

// ************************************************************
// reset values
// ************************************************************
`define TCP_RST_TM0 6'h00
`define TCP_RST_TM1 8'h00
`define TCP_RST_BYTE 8'h00
`define TCP_RST_HIGH_BITS 4'h0
`define TCP_RST_EDGE 2'h0

// ************************************************************
// codes and timing
// ************************************************************
`define TCP_T0_CLK_EXTERNAL 3'h7
`define TCP_T1_CLK_CHAIN 2'h3
`define TCP_EDGE_FALLING 0
`define TCP_EDGE_RISING 1
`define TCP_OSC_NS 250
`define TCP_CLK_NS 8
`define TCP_OSC_CYCLES ((`TCP_OSC_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)

`endif

// ==== rtl/tcp_pkg.sv ====
// types shared by the timer/pwm block
package tcp_pkg;

  // ************************************************************
  // whole state of the block, registered as one word
  // ************************************************************
  typedef struct packed {
    logic apbReady;         // apb ready, high from the first edge after reset
    logic [31:0] apbRdata;  // read data, captured in the setup cycle
    logic apbErr;           // unmapped address seen in setup cycle
    logic [5:0] tm0;        // timer0_mode_reg
    logic [7:0] tm1;        // timer1_mode_reg
    logic [7:0] matchLow;   // match_value_low
    logic [7:0] matchHigh;  // match_value_high
    logic [7:0] perLow;     // pwm_period_low
    logic [7:0] dutyLow;    // pwm_duty_low, holding stage
    logic [3:0] highBits;   // pwm_high_bits
    logic [7:0] portFunc;   // port5_function_reg
    logic [1:0] edgeSel;    // edge_select_reg
    logic [15:0] captureHold; // capture_hold_reg
    logic [7:0] t0Count;    // timer0 counter
    logic [9:0] t1Count;    // timer1 counter, shared by pwm
    logic [9:0] dutyActive; // active duty stage
    logic [15:0] oscCount;  // system clocks within one oscillator period
    logic [10:0] oscDiv;    // oscillator period counter feeding the prescaler
    logic ecSync1;
    logic ecSync2;
    logic ecPrev;
    logic trigSync1;
    logic trigSync2;
    logic trigPrev;
    logic t0Flag;           // timer0_match_flag
    logic trigFlag;         // external trigger flag
    logic pwmLevel;         // raw waveform
    logic pwmPin;           // waveform after the pin function gate
  } tcp_state_s;

endpackage : tcp_pkg

// ==== rtl/tcp_timer_pwm.sv ====
// timer0/timer1 with 16-bit capture and shared 10-bit pwm, apb registers
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "tcp_defines.svh"

// What this block does
// [RULE1] sixteen-bit capture chains both counters
// [RULE2] timer0 source prescaler or external pin
// [RULE3] software sets both clock bits plus chain
// [RULE4] pwm shares timer1 counter, exclusive use
// [RULE5] up to ten-bit pwm on pin
// [RULE6] software enables pin function bit six
// [RULE7] period is high bits 3:2 plus low
// [RULE8] duty is high bits 1:0 plus low
// [RULE9] duty double buffered, loaded at period match
// [RULE10] period and duty count source clocks
// [RULE11] clock codes give 250ns, 500ns, 2us
// [RULE12] duty equal period holds active level
// [RULE13] zero duty holds inactive level
// [RULE14] duty change waits for period end
// [RULE15] period change keeps existing duty
// [RULE16] software keeps period above duty
// [RULE17] trigger edge captures count, clears counter
// [RULE18] edge select picks edges, raises flag
// [RULE19] sixteen-bit match raises timer0 flag
// [RULE20] counter from zero, active until duty
module tcp_timer_pwm #(
  parameter int OSC_CYCLES = `TCP_OSC_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ec0Pin,
  input wire logic externalTriggerPin,
  output logic pwmPin,
  output logic timer0MatchFlag,
  output logic externalTriggerFlag
);

  // ************************************************************
  // helpers
  // ************************************************************

  // prescaler hit: all masked divider bits are ones on an oscillator tick
  function automatic logic prescaleHit(input logic [10:0] mask, input logic [10:0] div);
    prescaleHit = ((div & mask) == mask);
  endfunction : prescaleHit

  // register read decode; also tells whether the address is mapped
  function automatic logic [32:0] readReg(input logic [7:0] addr, input tcp_pkg::tcp_state_s s);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case (addr)
      `TCP_OFS_TIMER0_MODE: r[31:0] = {26'h000_0000, s.tm0};
      `TCP_OFS_TIMER1_MODE: r[31:0] = {24'h00_0000, s.tm1};
      `TCP_OFS_MATCH_LOW: r[31:0] = {24'h00_0000, s.matchLow};
      `TCP_OFS_MATCH_HIGH: r[31:0] = {24'h00_0000, s.matchHigh};
      `TCP_OFS_PERIOD_LOW: r[31:0] = {24'h00_0000, s.perLow};
      `TCP_OFS_DUTY_LOW: r[31:0] = {24'h00_0000, s.dutyLow};
      `TCP_OFS_HIGH_BITS: r[31:0] = {28'h000_0000, s.highBits};
      `TCP_OFS_PORT5_FUNC: r[31:0] = {24'h00_0000, s.portFunc};
      `TCP_OFS_EDGE_SELECT: r[31:0] = {30'h0000_0000, s.edgeSel};
      `TCP_OFS_CAPTURE_HOLD: r[31:0] = {16'h0000, s.captureHold};
      `TCP_OFS_STATUS: r[31:0] = {30'h0000_0000, s.trigFlag, s.t0Flag};
      default: r[32] = 1'b0;
    endcase
    readReg = r;
  endfunction : readReg

  // ************************************************************
  // state and decoded controls
  // ************************************************************
  tcp_pkg::tcp_state_s s_r; // registered state
  tcp_pkg::tcp_state_s s_nxt; // next state

  logic oscTick; // one oscillator period has passed
  logic t0Tick; // timer0 count event
  logic t1Tick; // pwm source clock event
  logic ecEdge; // either edge on ec0 after sync
  logic trigEdge; // selected edge on the trigger pin after sync
  logic chain; // counters joined into sixteen bits
  logic pwmOn; // pwm owns timer1
  logic captureOn; // capture mode on timer0
  logic [15:0] count16; // joined counter value
  logic [15:0] match16; // joined match value
  logic [9:0] period10; // ten-bit period
  logic [9:0] dutyHold10; // ten-bit holding duty
  logic pwmWrap; // pwm counter at the end of its period
  logic apbWrite; // write takes effect this edge
  logic [10:0] t0Mask;
  logic [10:0] t1Mask;

  // rule-facing decodes
  assign chain = s_r.tm1[`TCP_TM1_CHAIN] &&
                 (s_r.tm1[`TCP_TM1_CLK_LO +: 2] == `TCP_T1_CLK_CHAIN); // see [RULE3]
  assign pwmOn = s_r.tm1[`TCP_TM1_PWM_EN] && !chain && s_r.tm1[`TCP_TM1_RUN]; // see [RULE4]
  assign captureOn = s_r.tm0[`TCP_TM0_CAPTURE];
  assign count16 = {s_r.t1Count[7:0], s_r.t0Count}; // see [RULE1]
  assign match16 = {s_r.matchHigh, s_r.matchLow};
  assign period10 = {s_r.highBits[3:2], s_r.perLow}; // see [RULE7]
  assign dutyHold10 = {s_r.highBits[1:0], s_r.dutyLow}; // see [RULE8]
  assign oscTick = (s_r.oscCount == 16'(OSC_CYCLES - 1));
  assign apbWrite = psel && penable && pwrite && s_r.apbReady;

  // timer0 prescaler ratios 2..2048 of the oscillator
  always_comb begin
    unique case (s_r.tm0[`TCP_TM0_CLK_LO +: 3])
      3'h0: t0Mask = 11'h001;
      3'h1: t0Mask = 11'h003;
      3'h2: t0Mask = 11'h007;
      3'h3: t0Mask = 11'h01F;
      3'h4: t0Mask = 11'h07F;
      3'h5: t0Mask = 11'h1FF;
      default: t0Mask = 11'h7FF;
    endcase
  end

  // timer1 ratios 1, 2 and 8: 250ns, 500ns, 2us at the oscillator rate
  always_comb begin
    unique case (s_r.tm1[`TCP_TM1_CLK_LO +: 2])
      2'h0: t1Mask = 11'h000; // see [RULE11]
      2'h1: t1Mask = 11'h001; // see [RULE11]
      default: t1Mask = 11'h007; // see [RULE11]
    endcase
  end

  // external source only on code 7, else prescaler
  assign ecEdge = s_r.ecSync2 ^ s_r.ecPrev;
  assign t0Tick = s_r.tm0[`TCP_TM0_RUN] &&
                  ((s_r.tm0[`TCP_TM0_CLK_LO +: 3] == `TCP_T0_CLK_EXTERNAL) ? ecEdge :
                   (oscTick && prescaleHit(t0Mask, s_r.oscDiv))); // see [RULE2]
  // code 11 is the chain code and gives pwm no source clock
  assign t1Tick = oscTick && prescaleHit(t1Mask, s_r.oscDiv) &&
                  (s_r.tm1[`TCP_TM1_CLK_LO +: 2] != `TCP_T1_CLK_CHAIN);
  assign trigEdge = (s_r.edgeSel[`TCP_EDGE_FALLING] && s_r.trigPrev && !s_r.trigSync2) ||
                    (s_r.edgeSel[`TCP_EDGE_RISING] && !s_r.trigPrev && s_r.trigSync2); // see [RULE18]
  // a zero period never wraps; the counter keeps counting and rolls over at 1023
  assign pwmWrap = (period10 != 10'h000) && (s_r.t1Count >= period10 - 10'h001);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [32:0] rd;
    logic t0Set;
    logic trigSet;
    rd = readReg(paddr, s_r);
    s_nxt = s_r;
    t0Set = 1'b0;
    trigSet = trigEdge; // see [RULE18]
    s_nxt.apbReady = 1'b1; // zero wait states
    // synchronisers; first stages feed only the second
    s_nxt.ecSync1 = ec0Pin;
    s_nxt.ecSync2 = s_r.ecSync1;
    s_nxt.ecPrev = s_r.ecSync2;
    s_nxt.trigSync1 = externalTriggerPin;
    s_nxt.trigSync2 = s_r.trigSync1;
    s_nxt.trigPrev = s_r.trigSync2;
    // oscillator period and prescaler divider
    if (oscTick) begin
      s_nxt.oscCount = 16'h0000;
      s_nxt.oscDiv = s_r.oscDiv + 11'h001;
    end else begin
      s_nxt.oscCount = s_r.oscCount + 16'h0001;
    end
    // apb read data is latched in the setup cycle
    if (psel && !penable) begin
      s_nxt.apbRdata = pwrite ? 32'h0000_0000 : rd[31:0];
      s_nxt.apbErr = !rd[32];
    end
    // timer0, or the joined sixteen-bit counter
    if (captureOn && trigEdge) begin
      // capture beats a match in the same cycle
      s_nxt.captureHold = chain ? count16 : {8'h00, s_r.t0Count}; // see [RULE17] [RULE1]
      s_nxt.t0Count = 8'h00; // see [RULE17]
      if (chain) begin
        s_nxt.t1Count = 10'h000;
      end
    end else if (t0Tick) begin
      if (chain) begin
        if (count16 == match16) begin
          s_nxt.t0Count = 8'h00;
          s_nxt.t1Count = 10'h000;
          t0Set = 1'b1; // see [RULE19]
        end else begin
          s_nxt.t0Count = s_r.t0Count + 8'h01; // see [RULE1]
          s_nxt.t1Count = {2'b00, s_r.t1Count[7:0] + ((s_r.t0Count == 8'hFF) ? 8'h01 : 8'h00)};
        end
      end else if (s_r.t0Count == s_r.matchLow) begin
        s_nxt.t0Count = 8'h00;
        t0Set = 1'b1;
      end else begin
        s_nxt.t0Count = s_r.t0Count + 8'h01;
      end
    end
    // pwm on the timer1 counter
    if (!pwmOn) begin
      if (!chain) begin
        s_nxt.t1Count = 10'h000;
      end
      s_nxt.dutyActive = dutyHold10; // idle: new duty passes straight through
    end else if (t1Tick) begin
      if (pwmWrap) begin
        s_nxt.t1Count = 10'h000; // see [RULE20] [RULE10]
        s_nxt.dutyActive = dutyHold10; // see [RULE9] [RULE14]
      end else begin
        s_nxt.t1Count = s_r.t1Count + 10'h001; // see [RULE10]
      end
    end
    // level from the counter: active before duty match, clamped at both ends
    if (s_r.dutyActive == 10'h000) begin
      s_nxt.pwmLevel = !s_r.tm1[`TCP_TM1_ACTIVE_LEVEL]; // see [RULE13]
    end else if (s_r.dutyActive >= period10) begin
      s_nxt.pwmLevel = s_r.tm1[`TCP_TM1_ACTIVE_LEVEL]; // see [RULE12] [RULE15]
    end else begin
      s_nxt.pwmLevel = (s_r.t1Count < s_r.dutyActive) ?
                       s_r.tm1[`TCP_TM1_ACTIVE_LEVEL] : !s_r.tm1[`TCP_TM1_ACTIVE_LEVEL]; // see [RULE20]
    end
    s_nxt.pwmPin = s_r.portFunc[`TCP_PORT5_PWM_PIN] && pwmOn && s_r.pwmLevel; // see [RULE5] [RULE6]
    // register writes
    if (apbWrite) begin
      unique case (paddr)
        `TCP_OFS_TIMER0_MODE: begin
          s_nxt.tm0 = pwdata[5:0];
          if (pwdata[`TCP_TM0_RUN]) begin
            s_nxt.t0Count = 8'h00; // start clears the counter
            // a joined counter restarts from zero too, or a stale pwm count
            // would leak into the upper byte and push the match far away
            if (chain) begin
              s_nxt.t1Count = 10'h000; // see [RULE1]
            end
          end
        end
        `TCP_OFS_TIMER1_MODE: s_nxt.tm1 = pwdata[7:0];
        `TCP_OFS_MATCH_LOW: s_nxt.matchLow = pwdata[7:0];
        `TCP_OFS_MATCH_HIGH: s_nxt.matchHigh = pwdata[7:0];
        `TCP_OFS_PERIOD_LOW: s_nxt.perLow = pwdata[7:0]; // see [RULE15]
        `TCP_OFS_DUTY_LOW: s_nxt.dutyLow = pwdata[7:0]; // see [RULE9]
        `TCP_OFS_HIGH_BITS: s_nxt.highBits = pwdata[3:0];
        `TCP_OFS_PORT5_FUNC: s_nxt.portFunc = pwdata[7:0];
        `TCP_OFS_EDGE_SELECT: s_nxt.edgeSel = pwdata[1:0];
        `TCP_OFS_STATUS: begin
          s_nxt.t0Flag = s_r.t0Flag && !pwdata[`TCP_STAT_T0_MATCH];
          s_nxt.trigFlag = s_r.trigFlag && !pwdata[`TCP_STAT_TRIGGER];
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (t0Set) begin
      s_nxt.t0Flag = 1'b1;
    end
    if (trigSet) begin
      s_nxt.trigFlag = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.tm0 <= `TCP_RST_TM0;
      s_r.tm1 <= `TCP_RST_TM1;
      s_r.matchLow <= `TCP_RST_BYTE;
      s_r.highBits <= `TCP_RST_HIGH_BITS;
      s_r.edgeSel <= `TCP_RST_EDGE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.apbRdata;
  assign pready = s_r.apbReady;
  assign pslverr = s_r.apbErr;
  assign pwmPin = s_r.pwmPin;
  assign timer0MatchFlag = s_r.t0Flag;
  assign externalTriggerFlag = s_r.trigFlag;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  zero_duty_low_a: assert property ( // see [RULE13]
    (pwmOn && s_r.dutyActive == 10'h000) |=> (s_r.pwmLevel == !$past(s_r.tm1[7])))
    else $error("zero duty did not give the inactive level");

  full_duty_high_a: assert property ( // see [RULE12]
    (pwmOn && period10 != 10'h000 && s_r.dutyActive == period10)
    |=> (s_r.pwmLevel == $past(s_r.tm1[7])))
    else $error("full duty did not give the active level");

  duty_load_wrap_a: assert property ( // see [RULE9]
    (s_r.dutyActive != $past(s_r.dutyActive)) |-> $past(!pwmOn || (t1Tick && pwmWrap)))
    else $error("active duty changed in mid period");

  duty_hold_mid_a: assert property ( // see [RULE14]
    (pwmOn && !(t1Tick && pwmWrap)) |=> (s_r.dutyActive == $past(s_r.dutyActive)))
    else $error("duty write reached the output early");

  period_wrap_a: assert property ( // see [RULE20]
    (pwmOn && t1Tick && pwmWrap) |=> (s_r.t1Count == 10'h000))
    else $error("pwm counter did not clear at the period");

  capture_copy_a: assert property ( // see [RULE17]
    (captureOn && trigEdge && chain)
    |=> (s_r.captureHold == $past(count16)) && (count16 == 16'h0000))
    else $error("capture did not copy and clear the counter");

  chain_match_a: assert property ( // see [RULE19]
    (chain && t0Tick && !(captureOn && trigEdge) && count16 == match16)
    |=> s_r.t0Flag && (count16 == 16'h0000))
    else $error("sixteen-bit match missed the timer0 flag");

  trigger_flag_a: assert property ( // see [RULE18]
    trigEdge |=> s_r.trigFlag)
    else $error("trigger edge did not raise its flag");

  pin_gate_a: assert property ( // see [RULE6]
    !s_r.portFunc[6] |=> !s_r.pwmPin)
    else $error("pwm reached the pin without its function bit");

  start_clear_a: assert property ( // see [RULE1]
    (apbWrite && paddr == `TCP_OFS_TIMER0_MODE && pwdata[`TCP_TM0_RUN] && chain)
    |=> (count16 == 16'h0000))
    else $error("timer start left the joined counter running");

  apb_ready_a: assert property (
    (psel && penable) |-> pready)
    else $error("apb access saw no ready");

endmodule : tcp_timer_pwm

// ==== verification/tcp_pwm_load.sv ====
// load on the pwm pin: measures the last finished high run and low run in clocks
`timescale 1ns/1ns

module tcp_pwm_load (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pwmPin,
  output logic [15:0] highTime,
  output logic [15:0] lowTime
);
  // ************************************************************
  // run-length meter
  // ************************************************************
  logic [15:0] run_r; // clocks since the last level change
  logic last_r;       // level seen one clock ago

  // a run is only reported once it ends, so half-finished runs never show
  always_ff @(posedge clock) begin
    if (!resetn) begin
      run_r <= 16'h0001;
      last_r <= 1'b0;
      highTime <= 16'h0000;
      lowTime <= 16'h0000;
    end else begin
      last_r <= pwmPin;
      if (pwmPin !== last_r) begin
        run_r <= 16'h0001;
        if (last_r) begin
          highTime <= run_r;
        end else begin
          lowTime <= run_r;
        end
      end else begin
        run_r <= run_r + 16'h0001;
      end
    end
  end
endmodule : tcp_pwm_load

// ==== verification/timer_capture_and_pwm_tb_top.sv ====
// register-level testbench of the timer/pwm block
`timescale 1ns/1ns

module timer_capture_and_pwm_tb_top;
  // ************************************************************
  // signals
  // ************************************************************
  localparam int OSC = 2; // short oscillator divider keeps the run brief
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trigPin = 1'b1; // trigger line idles high
  logic ec0 = 1'b0; // external count line, toggled only by the count test
  logic pwmPin;
  logic t0Flag;
  logic trigFlag;
  logic [15:0] highTime;
  logic [15:0] lowTime;
  logic [31:0] rd;
  logic errSeen;
  int numErrors = 0;
  int checkCount = 0;
  int k[3] = '{2, 4, 16}; // clocks per source tick for codes 00, 01, 10

  always #4 clock = ~clock;

  tcp_timer_pwm #(.OSC_CYCLES(OSC)) dut_u (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ec0Pin(ec0), .externalTriggerPin(trigPin), .pwmPin(pwmPin),
    .timer0MatchFlag(t0Flag), .externalTriggerFlag(trigFlag)
  );

  tcp_pwm_load load_u (
    .clock(clock), .resetn(resetn), .pwmPin(pwmPin), .highTime(highTime), .lowTime(lowTime)
  );

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // one apb transfer; an idle cycle follows so strobes never change twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait for ready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : endOfTest

  // a hang counts as a mismatch
  initial begin
    cyc(60000);
    numErrors++;
    endOfTest();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    cyc(6);
    check(pready, 1'b0);
    resetn <= 1'b1;
    cyc(2);
    check(pready, 1'b1);
    // reset values, unmapped place, bits above a field
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    check(errSeen, 1'b1);
    apb(1'b1, 8'h08, 32'hFFFF_FF5A);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_005A);
    // period 260, duty 80, pin routed
    apb(1'b1, 8'h1C, 32'h0000_0040);
    apb(1'b1, 8'h10, 32'h0000_0004);
    apb(1'b1, 8'h14, 32'h0000_0050);
    apb(1'b1, 8'h18, 32'h0000_0004);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 8'h04, 32'h0000_00A1 | (c << 2));
      cyc(3 * 260 * k[c] + 10);
      check({highTime, lowTime}, {16'(80 * k[c]), 16'(180 * k[c])});
      check(32'(highTime) + 32'(lowTime), 32'(260 * k[c]));
    end
    apb(1'b1, 8'h04, 32'h0000_00A1);
    cyc(1200);
    // duty rewritten after the counter has passed the new value
    @(posedge pwmPin);
    @(posedge clock);
    cyc(40);
    apb(1'b1, 8'h14, 32'h0000_0010);
    cyc(200);
    check(highTime, 16'h00A0);
    cyc(1040);
    check(highTime, 16'h0020);
    // period grows, duty time stays
    apb(1'b1, 8'h10, 32'h0000_0040);
    cyc(1920);
    check({highTime, lowTime}, {16'h0020, 16'h0260});
    // duty at period and at zero, both polarities
    for (int active_level_select = 0; active_level_select < 2; active_level_select++) begin
      for (int s = 0; s < 2; s++) begin
        apb(1'b1, 8'h04, 32'h0000_0021 | (active_level_select << 7));
        apb(1'b1, 8'h14, s ? 32'h0000_0040 : 32'h0);
        apb(1'b1, 8'h18, s ? 32'h0000_0005 : 32'h0000_0004);
        cyc(1300);
        for (int j = 0; j < 4; j++) begin
          cyc(150);
          check(pwmPin, s ? active_level_select[0] : !active_level_select[0]);
        end
      end
    end
    // chained counters, match at 0x0103 ticks of four clocks
    apb(1'b1, 8'h04, 32'h0000_004C);
    apb(1'b1, 8'h08, 32'h0000_0003);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    apb(1'b1, 8'h28, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'h0000_0001);
    cyc(950);
    check({t0Flag, pwmPin}, 2'b00);
    cyc(150);
    check(t0Flag, 1'b1);
    // capture on falling edges only
    apb(1'b1, 8'h20, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0021);
    apb(1'b1, 8'h28, 32'h0000_0003);
    cyc(197);
    for (int m = 0; m < 2; m++) begin
      trigPin <= 1'b0;
      cyc(10);
      apb(1'b0, 8'h24, 32'h0);
      check(rd >= 45 && rd <= 55, 1'b1);
      check(trigFlag, 1'b1);
      apb(1'b1, 8'h28, 32'h0000_0002);
      trigPin <= 1'b1;
      cyc(10);
      check(trigFlag, 1'b0);
      cyc(158);
    end
    // rising edges only: a fall is ignored, a rise raises the flag
    apb(1'b1, 8'h20, 32'h0000_0002);
    apb(1'b1, 8'h28, 32'h0000_0002);
    trigPin <= 1'b0;
    cyc(10);
    check(trigFlag, 1'b0);
    trigPin <= 1'b1;
    cyc(10);
    check(trigFlag, 1'b1);
    // eight-bit timer0 on its external pin: both edges count, match 3 after four
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'h0000_001D);
    apb(1'b1, 8'h28, 32'h0000_0001);
    for (int e = 0; e < 4; e++) begin
      check(t0Flag, 1'b0);
      ec0 <= !ec0;
      cyc(10);
    end
    check(t0Flag, 1'b1);
    endOfTest();
  end
endmodule : timer_capture_and_pwm_tb_top
